// [hdl/fcd_decoder.sv]
// Command decoder for read modes, status clear and program sequences
//
// How it works
// [RULE1] 0xFF selects array read, full word
// [RULE2] 0x70 selects status read, low byte
// [RULE3] Program launch forces status read mode
// [RULE4] Identifier command selects identifier read, full word
// [RULE5] 0x98 selects query read, low byte
// [RULE6] Engine sets errors; only 0x50 clears
// [RULE7] 0x40 arms; next write launches word program
// [RULE8] While busy accept only status, suspend
// [RULE9] Host toggles select or output enable
// [RULE10] Host toggles select or address valid
// [RULE11] Host writes 0xFF before array reads
// [RULE12] 0x10 behaves exactly like 0x40
// [RULE13] 0xE8 starts buffer load, up to 32
// [RULE14] 0xD0 confirm launches buffered program
// [RULE15] 0x80 arms factory program, awaits 0xD0
// [RULE16] Factory mode ignores all other commands
// [RULE17] 0xD0 latches only right after 0x80
// [RULE18] Reset gives array read, status 0x80
// [RULE19] Bad second command sets status bits 4,5
// [RULE20] Capture at first rising strobe edge
// [RULE21] Identifier code taken as 0x90
// [RULE22] Unknown codes change nothing
`timescale 1ns/1ps
module fcd_decoder
  import fcd_pkg::*;
#(
  parameter int BUF_MAX = BUF_WORDS  // Program buffer size in words
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Host bus pins
  input  wire logic        chip_sel_n,
  input  wire logic        write_n,
  input  wire logic [23:0] addr_pin,
  input  wire logic [15:0] data_pin,
  // Read data sources
  input  wire logic [15:0] array_data,
  input  wire logic [15:0] ident_data,
  input  wire logic [7:0]  query_data,
  // Write state machine side
  input  wire logic        wsm_done,
  input  wire logic [7:0]  wsm_err_set,
  input  wire logic        wsm_factory_exit,
  // Outputs
  output fcd_launch_t      launch,
  output logic             buf_wr,
  output fcd_wr_t          buf_word,
  output logic             suspend_req,
  output fcd_rmode_t       read_mode,
  output logic [7:0]       status_reg,
  output logic [15:0]      read_data
);

  // Captured host write
  logic    wr_stb;
  fcd_wr_t wr;

  fcd_wr_capture u_cap (
    .core_clk   (core_clk),
    .reset      (reset),
    .chip_sel_n (chip_sel_n),
    .write_n    (write_n),
    .addr_pin   (addr_pin),
    .data_pin   (data_pin),
    .wr_stb     (wr_stb),
    .wr         (wr)
  );

  // All decoder state in one struct
  typedef struct packed {
    fcd_state_t  st;
    fcd_rmode_t  mode;
    logic [7:0]  sr;
    logic [5:0]  left;     // Words still to load into the buffer
    fcd_launch_t launch;
    logic        bwr;
    fcd_wr_t     bword;
    logic        susp;
    logic [15:0] rdata;
  } fcd_dec_t;

  fcd_dec_t q, d;

  // Read-mode change for single-cycle commands; returns current mode otherwise
  function automatic fcd_rmode_t mode_of(input logic [7:0] c, input fcd_rmode_t m);
    case (c)
      CMD_READ_ARRAY:  mode_of = RM_ARRAY;   // RULE1
      CMD_READ_STATUS: mode_of = RM_STATUS;  // RULE2
      CMD_READ_ID:     mode_of = RM_ID;      // RULE4 RULE21
      CMD_READ_QUERY:  mode_of = RM_QUERY;   // RULE5
      default:         mode_of = m;          // RULE22
    endcase
  endfunction

  // Sequence decode and status handling
  always_comb begin
    logic [7:0] c;
    c = wr.data[7:0];
    d = q;
    d.launch.valid = 1'b0;
    d.bwr  = 1'b0;
    d.susp = 1'b0;
    // Engine may only set error bits
    d.sr = q.sr | (wsm_err_set & SR_ERR_MASK); // RULE6
    if (wsm_done && q.st == ST_BUSY) begin
      d.st = ST_IDLE;
      d.sr[SR_READY] = 1'b1;
    end
    if (wsm_factory_exit && q.st == ST_FFP_RUN) begin
      d.st = ST_IDLE;
      d.sr[SR_READY] = 1'b1;
    end
    if (wr_stb) begin
      case (q.st)
        ST_IDLE: begin
          d.mode = mode_of(c, q.mode);
          case (c)
            CMD_CLEAR_SR: begin
              // A new error in this cycle still survives the clear
              d.sr = (q.sr & ~SR_ERR_MASK) | (wsm_err_set & SR_ERR_MASK); // RULE6
            end
            CMD_WORD_PGM, CMD_WORD_PGM_ALT: begin
              d.st = ST_PGM_ARM; // RULE7 RULE12
            end
            CMD_BUF_PGM: begin
              d.st   = ST_BUF_CNT; // RULE13
              d.mode = RM_STATUS;
            end
            CMD_FFP_SETUP: begin
              d.st = ST_FFP_ARM; // RULE15
            end
            default: begin
            end
          endcase
        end
        ST_PGM_ARM: begin
          // Second cycle latches address and data and launches
          d.launch = '{valid: 1'b1, op: OP_WORD, wr: wr}; // RULE7
          d.st   = ST_BUSY;
          d.mode = RM_STATUS; // RULE3
          d.sr[SR_READY] = 1'b0;
        end
        ST_BUF_CNT: begin
          // Word count is N-1; more than the buffer is a sequence error
          if (wr.data[7:0] >= 8'(BUF_MAX)) begin // RULE13
            d.sr[SR_PGM_E]   = 1'b1; // RULE19
            d.sr[SR_ERASE_E] = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.left = 6'(wr.data[7:0]) + 6'd1;
            d.st   = ST_BUF_LOAD;
          end
        end
        ST_BUF_LOAD: begin
          d.bwr   = 1'b1;
          d.bword = wr;
          d.left  = q.left - 6'd1;
          if (q.left == 6'd1) begin
            d.st = ST_BUF_CONF;
          end
        end
        ST_BUF_CONF: begin
          if (c == CMD_CONFIRM) begin
            d.launch = '{valid: 1'b1, op: OP_BUFFER, wr: wr}; // RULE14
            d.st = ST_BUSY;
            d.sr[SR_READY] = 1'b0;
          end else begin
            d.sr[SR_PGM_E]   = 1'b1; // RULE19
            d.sr[SR_ERASE_E] = 1'b1;
            d.st = ST_IDLE;
          end
          d.mode = RM_STATUS; // RULE3
        end
        ST_FFP_ARM: begin
          if (c == CMD_CONFIRM) begin
            d.launch = '{valid: 1'b1, op: OP_FACTORY, wr: wr}; // RULE17
            d.st = ST_FFP_RUN;
            d.sr[SR_READY] = 1'b0;
          end else begin
            d.sr[SR_PGM_E]   = 1'b1; // RULE19
            d.sr[SR_ERASE_E] = 1'b1;
            d.st = ST_IDLE;
          end
          d.mode = RM_STATUS; // RULE3
        end
        ST_FFP_RUN: begin
          // Writes here are factory data words, never commands
          d.bwr   = 1'b1; // RULE16
          d.bword = wr;
        end
        ST_BUSY: begin
          if (c == CMD_READ_STATUS) begin
            d.mode = RM_STATUS; // RULE8
          end else if (c == CMD_SUSPEND) begin
            d.susp = 1'b1; // RULE8
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end
    // Read mux; status and query occupy the low byte only
    case (d.mode)
      RM_ARRAY:  d.rdata = array_data;            // RULE1
      RM_STATUS: d.rdata = {8'h00, d.sr};         // RULE2
      RM_ID:     d.rdata = ident_data;            // RULE4
      RM_QUERY:  d.rdata = {8'h00, query_data};   // RULE5
      default:   d.rdata = 16'h0000;
    endcase
  end

  // State register; reset gives array read and ready status
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.mode <= RM_ARRAY;  // RULE18
      q.sr   <= SR_RESET;  // RULE18
    end else begin
      q <= d;
    end
  end

  assign launch      = q.launch;
  assign buf_wr      = q.bwr;
  assign buf_word    = q.bword;
  assign suspend_req = q.susp;
  assign read_mode   = q.mode;
  assign status_reg  = q.sr;
  assign read_data   = q.rdata;

  // Checks
  sequence s_cmd(logic [7:0] v);
    wr_stb && wr.data[7:0] == v;
  endsequence

  property p_array;
    @(posedge core_clk) disable iff (reset)
      (s_cmd(CMD_READ_ARRAY) and (q.st == ST_IDLE)) |=> read_mode == RM_ARRAY;
  endproperty
  a_array: assert property (p_array) else $error("array read not entered"); // RULE1

  property p_status;
    @(posedge core_clk) disable iff (reset)
      (s_cmd(CMD_READ_STATUS) and (q.st inside {ST_IDLE, ST_BUSY}))
      |=> read_mode == RM_STATUS ##1 read_data[15:8] == 8'h00;
  endproperty
  a_status: assert property (p_status) else $error("status read not entered"); // RULE2

  property p_launch_status;
    @(posedge core_clk) disable iff (reset)
      launch.valid |-> read_mode == RM_STATUS && !status_reg[SR_READY];
  endproperty
  a_launch_status: assert property (p_launch_status) else $error("no status after launch"); // RULE3

  property p_query;
    @(posedge core_clk) disable iff (reset)
      (s_cmd(CMD_READ_QUERY) and (q.st == ST_IDLE)) |=> read_mode == RM_QUERY;
  endproperty
  a_query: assert property (p_query) else $error("query read not entered"); // RULE5

  property p_err_hold;
    @(posedge core_clk) disable iff (reset)
      !(wr_stb && q.st == ST_IDLE && wr.data[7:0] == CMD_CLEAR_SR)
      |=> ((status_reg & SR_ERR_MASK) & $past(status_reg & SR_ERR_MASK))
          == $past(status_reg & SR_ERR_MASK);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error bit lost"); // RULE6

  // Word program has two steps: the setup code arms, the next write launches
  sequence s_word_arm;
    wr_stb && q.st == ST_IDLE
      && (wr.data[7:0] == CMD_WORD_PGM || wr.data[7:0] == CMD_WORD_PGM_ALT);
  endsequence

  // Any write after arming is the address and data of the word
  sequence s_word_data;
    wr_stb && q.st == ST_PGM_ARM;
  endsequence

  property p_word;
    @(posedge core_clk) disable iff (reset)
      s_word_arm |=> q.st == ST_PGM_ARM;
  endproperty
  a_word: assert property (p_word) else $error("word program not armed"); // RULE7 RULE12

  property p_word_go;
    @(posedge core_clk) disable iff (reset)
      s_word_data |=> launch.valid && launch.op == OP_WORD && launch.wr == $past(wr);
  endproperty
  a_word_go: assert property (p_word_go) else $error("word program not launched"); // RULE7

  property p_busy;
    @(posedge core_clk) disable iff (reset)
      q.st == ST_BUSY |=> !launch.valid;
  endproperty
  a_busy: assert property (p_busy) else $error("command taken while busy"); // RULE8

  property p_ffp;
    @(posedge core_clk) disable iff (reset)
      launch.valid && launch.op == OP_FACTORY |-> $past(q.st) == ST_FFP_ARM;
  endproperty
  a_ffp: assert property (p_ffp) else $error("factory launch without setup"); // RULE17

  // Factory mode turns every write into a data word, whatever its code
  property p_ffp_run;
    @(posedge core_clk) disable iff (reset)
      wr_stb && q.st == ST_FFP_RUN |=> buf_wr && !launch.valid && read_mode == RM_STATUS;
  endproperty
  a_ffp_run: assert property (p_ffp_run) else $error("command taken in factory mode"); // RULE16

  property p_seq_err;
    @(posedge core_clk) disable iff (reset)
      wr_stb && q.st == ST_FFP_ARM && wr.data[7:0] != CMD_CONFIRM
      |=> status_reg[SR_PGM_E] && status_reg[SR_ERASE_E];
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged"); // RULE19

endmodule

// [hdl/fcd_wr_capture.sv]
// Write-cycle capture: synchronises strobes and latches at first rising edge
`timescale 1ns/1ps
module fcd_wr_capture
  import fcd_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Pins (asynchronous to core_clk)
  input  wire logic        chip_sel_n,
  input  wire logic        write_n,
  input  wire logic [23:0] addr_pin,
  input  wire logic [15:0] data_pin,
  // Captured write
  output logic             wr_stb,
  output fcd_wr_t          wr
);

  // All capture state in one struct
  typedef struct packed {
    logic [1:0] ce_s1;     // First stage, read only by second stage
    logic [1:0] ce_s2;     // Synced {chip_sel_n, write_n}
    logic       active_q;  // Write cycle in progress
    fcd_wr_t    bus_s1;
    fcd_wr_t    bus_s2;
    logic       stb;
    fcd_wr_t    wr;
  } fcd_cap_t;

  fcd_cap_t q, d;

  // A write is active while both strobes are low; it ends at whichever rises first
  always_comb begin
    d        = q;
    d.ce_s1  = {chip_sel_n, write_n};
    d.ce_s2  = q.ce_s1;
    d.bus_s1 = '{addr: addr_pin, data: data_pin};
    d.bus_s2 = q.bus_s1;
    d.stb    = 1'b0;
    d.active_q = (q.ce_s2 == 2'b00);
    // Data held from the last active sample, so the first rising strobe wins
    if (q.active_q && q.ce_s2 != 2'b00) begin // RULE20
      d.stb = 1'b1;
    end
    if (q.ce_s2 == 2'b00) begin
      d.wr = q.bus_s2;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.ce_s1 <= 2'b11;
      q.ce_s2 <= 2'b11;
    end else begin
      q <= d;
    end
  end

  assign wr_stb = q.stb;
  assign wr     = q.wr;

endmodule

// [include/fcd_pkg.sv]
// Shared constants and types for the flash command decoder
package fcd_pkg;

  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_CLEAR_SR    = 8'h50;
  localparam logic [7:0] CMD_WORD_PGM    = 8'h40;
  localparam logic [7:0] CMD_WORD_PGM_ALT = 8'h10;
  localparam logic [7:0] CMD_BUF_PGM     = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_FFP_SETUP   = 8'h80;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;

  // Status register layout and reset value
  localparam logic [7:0] SR_RESET   = 8'h80;
  localparam int         SR_READY   = 7;
  localparam int         SR_ERASE_E = 5;
  localparam int         SR_PGM_E   = 4;
  localparam logic [7:0] SR_ERR_MASK = 8'h3A;

  // Buffered program limit in words
  localparam int BUF_WORDS = 32;

  // Read modes
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} fcd_rmode_t;

  // Decoder sequence states
  typedef enum logic [2:0] {
    ST_IDLE, ST_PGM_ARM, ST_BUF_CNT, ST_BUF_LOAD, ST_BUF_CONF,
    ST_FFP_ARM, ST_FFP_RUN, ST_BUSY
  } fcd_state_t;

  // Operation launched to the write state machine
  typedef enum logic [1:0] {OP_WORD, OP_BUFFER, OP_FACTORY} fcd_op_t;

  // One captured bus write
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
  } fcd_wr_t;

  // Launch request to the write state machine
  typedef struct packed {
    logic    valid;
    fcd_op_t op;
    fcd_wr_t wr;
  } fcd_launch_t;

endpackage

// [tb/fcd_decoder_bench.sv]
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module fcd_decoder_bench
  import fcd_pkg::*;
;
  logic        core_clk, reset, chip_sel_n, write_n;
  logic [23:0] addr_pin;
  logic [15:0] data_pin, array_data, ident_data, read_data;
  logic [7:0]  query_data, wsm_err_set, status_reg, err_code;
  logic        wsm_done, wsm_factory_exit, buf_wr, suspend_req, slow;
  fcd_launch_t launch, last_l;
  fcd_wr_t     buf_word, last_bw;
  fcd_rmode_t  read_mode;
  int          failures, checks, n_launch, n_buf, n_sus, nl, nb, ns;
  logic [7:0]  pg [2];

  fcd_decoder u_dut (.core_clk(core_clk), .reset(reset), .chip_sel_n(chip_sel_n),
    .write_n(write_n), .addr_pin(addr_pin), .data_pin(data_pin), .array_data(array_data),
    .ident_data(ident_data), .query_data(query_data), .wsm_done(wsm_done),
    .wsm_err_set(wsm_err_set), .wsm_factory_exit(wsm_factory_exit), .launch(launch),
    .buf_wr(buf_wr), .buf_word(buf_word), .suspend_req(suspend_req),
    .read_mode(read_mode), .status_reg(status_reg), .read_data(read_data));

  fcd_wsm_model u_wsm (.core_clk(core_clk), .reset(reset), .launch(launch), .slow(slow),
    .err_code(err_code), .wsm_done(wsm_done), .wsm_err_set(wsm_err_set),
    .wsm_factory_exit(wsm_factory_exit));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // One-cycle pulses are counted here, since tests look later
  always @(posedge core_clk) begin
    if (launch.valid === 1'b1) begin
      n_launch++;
      last_l = launch;
    end
    if (buf_wr === 1'b1) begin
      n_buf++;
      last_bw = buf_word;
    end
    if (suspend_req === 1'b1) n_sus++;
  end

  task summarize;
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobes low 4 clocks, then high long enough for the 4-clock answer
  task wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge core_clk);
    chip_sel_n <= 1'b0;
    write_n <= 1'b0;
    addr_pin <= a;
    data_pin <= d;
    repeat (4) @(posedge core_clk);
    write_n <= 1'b1;
    chip_sel_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  task mode(input fcd_rmode_t m, input logic [7:0] sr);
    chk("read_mode", {14'h0000, read_mode}, {14'h0000, m});
    chk("status_reg", {8'h00, status_reg}, {8'h00, sr});
  endtask

  // Bounded wait for the ready bit
  task wait_ready;
    for (int i = 0; i < 200 && status_reg[7] !== 1'b1; i++) @(posedge core_clk);
    // A wait that runs out is a mismatch of its own
    chk("ready_wait", {15'h0000, status_reg[7]}, 16'h0001);
  endtask

  // Hang guard, far beyond the expected run of about 860 cycles
  initial begin
    repeat (8000) @(posedge core_clk);
    failures++;
    summarize;
  end

  initial begin
    {chip_sel_n, write_n} = 2'b11;
    {addr_pin, data_pin, slow, err_code} = '0;
    {failures, checks, n_launch, n_buf, n_sus} = '0;
    array_data = 16'hA55A;
    ident_data = 16'h1E2D;
    query_data = 8'h51;
    pg = '{CMD_WORD_PGM, CMD_WORD_PGM_ALT};
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    // Read modes
    mode(RM_ARRAY, 8'h80);
    chk("array", read_data, 16'hA55A);
    wr(24'h00_0000, 16'h0070);
    mode(RM_STATUS, 8'h80);
    chk("status", read_data, 16'h0080);
    wr(24'h00_0000, 16'h0090);
    chk("ident", read_data, 16'h1E2D);
    wr(24'h00_0000, 16'h0098);
    chk("query", read_data, 16'h0051);
    wr(24'h00_0000, 16'h0033);
    mode(RM_QUERY, 8'h80);
    wr(24'h00_0000, 16'h00FF);
    mode(RM_ARRAY, 8'h80);
    // Word program through both setup codes, probed while busy
    slow <= 1'b1;
    foreach (pg[i]) begin
      nl = n_launch;
      ns = n_sus;
      wr(24'h00_0000, {8'h00, pg[i]});
      wr(24'h00_0A00 | 24'(i), 16'hC3A5 ^ 16'(i));
      chk("launches", 16'(n_launch - nl), 16'h0001);
      chk("op", {14'h0000, last_l.op}, {14'h0000, OP_WORD});
      chk("addr", last_l.wr.addr[15:0], 16'h0A00 | 16'(i));
      chk("data", last_l.wr.data, 16'hC3A5 ^ 16'(i));
      mode(RM_STATUS, 8'h00);
      wr(24'h00_0000, 16'h00FF);
      wr(24'h00_0000, {8'h00, CMD_SUSPEND});
      mode(RM_STATUS, 8'h00);
      chk("suspend", 16'(n_sus - ns), 16'h0001);
      wait_ready;
      chk("ready", {8'h00, status_reg}, 16'h0080);
      wr(24'h00_0000, 16'h00FF);
      mode(RM_ARRAY, 8'h80);
    end
    // Engine error sticks until clear-status
    slow <= 1'b0;
    err_code <= 8'h10;
    wr(24'h00_0000, 16'h0040);
    wr(24'h00_0B00, 16'h1234);
    wait_ready;
    err_code <= 8'h00;
    wr(24'h00_0000, 16'h00FF);
    mode(RM_ARRAY, 8'h90);
    wr(24'h00_0000, 16'h0050);
    chk("cleared", {8'h00, status_reg}, 16'h0080);
    // Bad second cycle after factory setup, then a stray confirm
    nl = n_launch;
    wr(24'h00_0000, 16'h0080);
    wr(24'h00_0000, 16'h00FF);
    chk("seq_err", {8'h00, status_reg}, 16'h00B0);
    wr(24'h00_0000, 16'h00D0);
    chk("no_launch", 16'(n_launch - nl), 16'h0000);
    wr(24'h00_0000, 16'h0050);
    // Count of 33 words is over the buffer and flags a sequence error
    wr(24'h00_2000, 16'h00E8);
    wr(24'h00_2000, 16'h0020);
    chk("buf_over", {8'h00, status_reg}, 16'h00B0);
    wr(24'h00_0000, 16'h0050);
    // Buffered program of three words
    nb = n_buf;
    wr(24'h00_2000, 16'h00E8);
    wr(24'h00_2000, 16'h0002);
    for (int k = 0; k < 3; k++) wr(24'h00_2000 + 24'(k), 16'h5A00 + 16'(k));
    wr(24'h00_2000, 16'h00D0);
    chk("buf_words", 16'(n_buf - nb), 16'h0003);
    chk("buf_data", last_bw.data, 16'h5A02);
    chk("buf_addr", last_bw.addr[15:0], 16'h2002);
    chk("buf_op", {14'h0000, last_l.op}, {14'h0000, OP_BUFFER});
    mode(RM_STATUS, 8'h00);
    wait_ready;
    // Factory program: command codes become data words
    wr(24'h00_3000, 16'h0080);
    wr(24'h00_3000, 16'h00D0);
    chk("ffp_op", {14'h0000, last_l.op}, {14'h0000, OP_FACTORY});
    nb = n_buf;
    wr(24'h00_3000, 16'h00FF);
    chk("ffp_word", 16'(n_buf - nb), 16'h0001);
    chk("ffp_data", last_bw.data, 16'h00FF);
    chk("ffp_mode", {14'h0000, read_mode}, {14'h0000, RM_STATUS});
    repeat (320) @(posedge core_clk);
    wr(24'h00_0000, 16'h00FF);
    chk("final_mode", {14'h0000, read_mode}, {14'h0000, RM_ARRAY});
    summarize;
  end
endmodule

// [tb/fcd_wsm_model.sv]
// Behavioural write state machine that answers program launches
`timescale 1ns/1ps
module fcd_wsm_model
  import fcd_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Launch and bench controls
  input  wire fcd_launch_t launch,
  input  wire logic        slow,
  input  wire logic [7:0]  err_code,
  // Completion back to the decoder
  output logic             wsm_done,
  output logic [7:0]       wsm_err_set,
  output logic             wsm_factory_exit
);
  logic [8:0] left_q;  // Cycles until the job ends
  fcd_op_t    op_q;    // Kind of job running

  // Count a job down; slow mode keeps it busy long enough to probe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      left_q <= 9'h000;
      op_q <= OP_WORD;
      wsm_done <= 1'b0;
      wsm_err_set <= 8'h00;
      wsm_factory_exit <= 1'b0;
    end else begin
      wsm_done <= 1'b0;
      wsm_err_set <= 8'h00;
      wsm_factory_exit <= 1'b0;
      if (launch.valid) begin
        op_q <= launch.op;
        left_q <= (launch.op == OP_FACTORY) ? 9'h12C : (slow ? 9'h03C : 9'h003);
      end else if (left_q == 9'h001) begin
        left_q <= 9'h000;
        if (op_q == OP_FACTORY) begin
          wsm_factory_exit <= 1'b1;
        end else begin
          // Engine only ever sets error bits
          wsm_done <= 1'b1;
          wsm_err_set <= err_code;
        end
      end else if (left_q != 9'h000) begin
        left_q <= left_q - 9'h001;
      end
    end
  end
endmodule
